// ---- kms_pkg.sv ----
// kms_pkg: constants and types for the key matrix scanner
// assumes nothing beyond a SystemVerilog compiler
package kms_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ROWS = 8;
    localparam int COLS = 8;
    localparam int KEYS = ROWS * COLS;
    localparam int DEB_W = 8;
    localparam logic [DEB_W-1:0] DEB_RST = 8'h04;
    localparam logic [ROWS-1:0] ROWS_ALL = 8'hff;
    localparam logic [ROWS-1:0] ROW_FIRST = 8'h01;
    localparam logic [COLS-1:0] COLS_NONE = 8'h00;
    localparam logic [KEYS-1:0] KEYS_NONE = 64'h0;
    localparam logic [2:0] ROW_LAST = 3'h7;
    localparam logic [2:0] ROW_ZERO = 3'h0;
    localparam logic [2:0] ROW_ONE = 3'h1;
    localparam logic [DEB_W-1:0] DEB_ZERO = 8'h00;
    localparam logic [DEB_W-1:0] DEB_ONE = 8'h01;
    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        KMS_IDLE = 4'b0001,
        KMS_SCAN = 4'b0010,
        KMS_DEB = 4'b0100,
        KMS_STORE = 4'b1000
    } kms_state_t;
endpackage

// ---- kms_scanner.sv ----
// kms_scanner: automatic 8x8 key matrix scanner
// assumes column inputs synchronous to i_ref_clk, a settle of one tick per row
//
// Behaviour
// RQ1 - eight row drives, eight column senses, sixty-four key positions
// RQ2 - idle: all rows high, wait for any column to go active
// RQ3 - scan drives one row at a time, samples columns per row
// RQ4 - debounce scan, then latch state and pulse interrupt
// RQ5 - after report keep rescanning for added or released keys
// RQ6 - each changed debounced state is stored and gets a new interrupt
// RQ7 - one bit per key, any combination of keys reported
// RQ8 - debounce length set by software period input
// RQ9 - a column going active in idle raises a wake-up pulse for stop mode
// RQ10 - runs at any tick rate, e.g. 32768 Hz enable pulse
// RQ11 - empty debounced state is reported, then back to idle
`timescale 1ns/1ns
module kms_scanner (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_scan_tick,
    input wire logic [kms_pkg::DEB_W-1:0] i_deb_period,
    input wire logic [kms_pkg::COLS-1:0] i_matrix_col,
    output logic [kms_pkg::ROWS-1:0] o_matrix_row_drive_n,
    output logic [kms_pkg::KEYS-1:0] o_key_state,
    output logic o_key_irq,
    output logic o_key_wake
);
    import kms_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    kms_state_t state_r, state_nxt;
    logic [2:0] row_r, row_nxt;
    logic [DEB_W-1:0] deb_r, deb_nxt;
    logic [KEYS-1:0] scan_r, scan_nxt;
    logic [KEYS-1:0] prev_r, prev_nxt;
    logic [KEYS-1:0] key_r, key_nxt;
    logic [ROWS-1:0] drive_r, drive_nxt;
    logic irq_r, irq_nxt;
    logic wake_r, wake_nxt;

    // ------------------------------------------------------------
    // decodes
    // ------------------------------------------------------------
    logic col_hit;
    logic row_end;
    logic scan_same;
    logic deb_done;
    logic scan_empty;
    logic scan_new;
    assign col_hit = (i_matrix_col != COLS_NONE); // RQ2
    assign row_end = (row_r == ROW_LAST);
    assign scan_same = (scan_r == prev_r); // RQ4
    assign deb_done = (deb_r >= i_deb_period); // RQ8
    assign scan_empty = (scan_r == KEYS_NONE); // RQ11
    assign scan_new = (scan_r != key_r); // RQ6

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        if (i_scan_tick) begin // RQ10
            case (state_r)
                KMS_IDLE: begin
                    if (col_hit) begin // RQ2
                        state_nxt = KMS_SCAN;
                    end
                end
                KMS_SCAN: begin
                    if (row_end) begin
                        state_nxt = KMS_DEB;
                    end
                end
                KMS_DEB: begin
                    // scan must repeat unchanged for the programmed period
                    if (!scan_same) begin // RQ4
                        state_nxt = KMS_SCAN;
                    end else if (deb_done) begin // RQ8
                        state_nxt = KMS_STORE;
                    end else begin
                        state_nxt = KMS_SCAN; // RQ4
                    end
                end
                KMS_STORE: begin
                    if (scan_empty) begin // RQ11
                        state_nxt = KMS_IDLE;
                    end else begin
                        state_nxt = KMS_SCAN; // RQ5
                    end
                end
                default: begin
                    state_nxt = KMS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= KMS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // row drive
    // ------------------------------------------------------------
    always_comb begin
        row_nxt = row_r;
        drive_nxt = drive_r;
        if (i_scan_tick) begin // RQ10
            case (state_r)
                KMS_IDLE: begin
                    drive_nxt = ROWS_ALL; // RQ2
                    if (col_hit) begin
                        row_nxt = ROW_ZERO;
                        drive_nxt = ROW_FIRST; // RQ3
                    end
                end
                KMS_SCAN: begin
                    if (row_end) begin
                        row_nxt = ROW_ZERO;
                        drive_nxt = ROW_FIRST;
                    end else begin
                        row_nxt = row_r + ROW_ONE;
                        drive_nxt = ROW_FIRST << (row_r + ROW_ONE); // RQ3
                    end
                end
                KMS_DEB: begin
                    // first row stays driven for the rescan
                    drive_nxt = drive_r;
                end
                KMS_STORE: begin
                    if (scan_empty) begin // RQ11
                        drive_nxt = ROWS_ALL;
                    end
                end
                default: begin
                    row_nxt = ROW_ZERO;
                    drive_nxt = ROWS_ALL;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            row_r <= ROW_ZERO;
            drive_r <= ROWS_ALL;
        end else begin
            row_r <= row_nxt;
            drive_r <= drive_nxt;
        end
    end

    // ------------------------------------------------------------
    // scan capture and debounce
    // ------------------------------------------------------------
    always_comb begin
        deb_nxt = deb_r;
        scan_nxt = scan_r;
        prev_nxt = prev_r;
        if (i_scan_tick) begin // RQ10
            case (state_r)
                KMS_IDLE: begin
                    if (col_hit) begin
                        deb_nxt = DEB_ZERO;
                    end
                end
                KMS_SCAN: begin
                    // one bit per key position
                    scan_nxt[row_r*COLS +: COLS] = i_matrix_col; // RQ1 RQ7 RQ3
                end
                KMS_DEB: begin
                    if (!scan_same) begin // RQ4
                        prev_nxt = scan_r;
                        deb_nxt = DEB_ZERO;
                    end else if (!deb_done) begin // RQ8
                        deb_nxt = deb_r + DEB_ONE;
                    end
                end
                KMS_STORE: begin
                    deb_nxt = DEB_ZERO;
                end
                default: begin
                    deb_nxt = DEB_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            deb_r <= DEB_ZERO;
            scan_r <= KEYS_NONE;
            prev_r <= KEYS_NONE;
        end else begin
            deb_r <= deb_nxt;
            scan_r <= scan_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ------------------------------------------------------------
    // report
    // ------------------------------------------------------------
    always_comb begin
        key_nxt = key_r;
        irq_nxt = 1'b0;
        wake_nxt = 1'b0;
        if (i_scan_tick) begin // RQ10
            case (state_r)
                KMS_IDLE: begin
                    if (col_hit) begin
                        wake_nxt = 1'b1; // RQ9
                    end
                end
                KMS_STORE: begin
                    if (scan_new) begin // RQ6
                        key_nxt = scan_r; // RQ4
                        irq_nxt = 1'b1; // RQ4 RQ6
                    end
                end
                default: begin
                    key_nxt = key_r;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_r <= KEYS_NONE;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            key_r <= key_nxt;
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign o_matrix_row_drive_n = drive_r;
    assign o_key_state = key_r;
    assign o_key_irq = irq_r;
    assign o_key_wake = wake_r;
endmodule

// ---- kms_matrix.sv ----
// kms_matrix: behavioural 8x8 key switch matrix
// assumes a driven row is high; open columns read low
`timescale 1ns/1ns
module kms_matrix (
    input wire logic [7:0] i_rows,
    input wire logic [63:0] i_keys,
    output logic [7:0] o_cols
);
    always_comb begin
        o_cols = 8'h00;
        for (int r = 0; r < 8; r++) begin
            if (i_rows[r]) begin
                o_cols = o_cols | i_keys[r*8 +: 8];
            end
        end
    end
endmodule

// ---- kms_scanner_props.sv ----
// kms_scanner_props: port checker for kms_scanner
// assumes tick-paced scanning
`timescale 1ns/1ns
module kms_scanner_props (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_scan_tick,
    input wire logic [7:0] i_deb_period,
    input wire logic [7:0] i_matrix_col,
    input wire logic [7:0] o_matrix_row_drive_n,
    input wire logic [63:0] o_key_state,
    input wire logic o_key_irq,
    input wire logic o_key_wake
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_wake_from_idle: assert property (o_key_wake |-> $past(i_scan_tick) &&
        $past(o_matrix_row_drive_n) == 8'hff && $past(i_matrix_col) != 8'h00) else $error("wake");
    a_wake_row_one: assert property (o_key_wake |-> o_matrix_row_drive_n == 8'h01)
        else $error("wake row");
    a_row_onehot: assert property (o_matrix_row_drive_n == 8'hff
        || $onehot(o_matrix_row_drive_n)) else $error("rows");
    a_irq_pulse: assert property (o_key_irq |=> !o_key_irq) else $error("irq long");
    a_irq_changed: assert property (o_key_irq |-> $changed(o_key_state)) else $error("irq");
    a_state_irq: assert property ($changed(o_key_state) |-> o_key_irq) else $error("state");
    a_rows_tick: assert property (!$past(i_scan_tick) |-> $stable(o_matrix_row_drive_n))
        else $error("row step");
    a_empty_idle: assert property (o_key_irq && o_key_state == 64'h0
        |-> o_matrix_row_drive_n == 8'hff) else $error("empty");
    a_keep_scan: assert property (o_key_irq && o_key_state != 64'h0
        |-> o_matrix_row_drive_n == 8'h01) else $error("rescan");
endmodule
bind kms_scanner kms_scanner_props u_props (.*);

// ---- kms_scanner_tb.sv ----
// kms_scanner_tb: self-checking bench for kms_scanner
// assumes kms_matrix as the far-side key matrix
`timescale 1ns/1ns
`define CHK(a, b) if ((a) !== (b)) begin $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); error_cnt++; end check_count++;
module kms_scanner_tb;
    import kms_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tick = 1'b0;
    logic [DEB_W-1:0] per = 8'h01;
    logic [KEYS-1:0] keys = 64'h0;
    logic [COLS-1:0] cols;
    logic [ROWS-1:0] rows;
    logic [KEYS-1:0] st;
    logic irq;
    logic wake;
    int error_cnt = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    kms_matrix mat (.i_rows(rows), .i_keys(keys), .o_cols(cols));
    kms_scanner dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_scan_tick(tick), .i_deb_period(per),
        .i_matrix_col(cols), .o_matrix_row_drive_n(rows), .o_key_state(st), .o_key_irq(irq),
        .o_key_wake(wake));
    task automatic final_report();
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wait_sig(ref logic s, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (s !== 1'b1 && n < 500);
        if (s !== 1'b1) begin
            error_cnt++;
        end
    endtask
    task automatic t_press();
        int n;
        @(posedge clk);
        keys <= 64'h8000_0000_0000_0001;
        wait_sig(wake, n);
        wait_sig(irq, n);
        `CHK(n, 56)
        `CHK(st, 64'h8000_0000_0000_0001)
    endtask
    task automatic t_add();
        int n;
        @(posedge clk);
        per <= 8'h00;
        keys <= 64'h8000_0010_0000_0001;
        wait_sig(irq, n);
        `CHK(st, 64'h8000_0010_0000_0001)
    endtask
    task automatic t_release();
        int n;
        @(posedge clk);
        keys <= KEYS_NONE;
        wait_sig(irq, n);
        `CHK(st, KEYS_NONE)
        `CHK(rows, ROWS_ALL)
    endtask
    task automatic t_all();
        int n;
        @(posedge clk);
        keys <= {KEYS{1'b1}};
        wait_sig(irq, n);
        `CHK(st, {KEYS{1'b1}})
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_press();
        t_add();
        t_release();
        t_all();
        t_release();
        final_report();
    end
    initial begin
        #40000;
        error_cnt++;
        final_report();
    end
endmodule
